// [src/pin_edge_if.sv]
// Interface carrying synchronised pin levels and their rising edges.
// Assumes the producer and the consumer share the system clock.
`timescale 1ns/100ps
`default_nettype none
interface pin_edge_if #(parameter int N = 3);
    logic [N-1:0] level;
    logic [N-1:0] rise;
    modport sampler (output level, output rise);
    modport user (input level, input rise);
endinterface : pin_edge_if
`default_nettype wire

// [src/pin_sampler.sv]
// Two-stage synchroniser and rise detector for a group of pins.
// Assumes the pins are asynchronous to clock; ce freezes every stage.
`timescale 1ns/100ps
`default_nettype none
module pin_sampler #(
    parameter int N = 3
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [N-1:0] pins,
    pin_edge_if.sampler edges
);
    logic [N-1:0] meta_reg;
    logic [N-1:0] sync_reg;
    logic [N-1:0] last_reg;
    logic [N-1:0] meta_next;
    logic [N-1:0] sync_next;
    logic [N-1:0] last_next;

    // Only the second stage reads the first; edges come from stages two and three
    always_comb begin
        meta_next = ce ? pins : meta_reg;
        sync_next = ce ? meta_reg : sync_reg;
        last_next = ce ? sync_reg : last_reg;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    // One rise detector per pin
    for (genvar i = 0; i < N; i++) begin : g_edge
        assign edges.rise[i] = sync_reg[i] & ~last_reg[i];
        assign edges.level[i] = sync_reg[i];
    end
endmodule : pin_sampler
`default_nettype wire

// [src/tx_clk_pkg.sv]
// Package for the transmit clock source selector.
// Assumes a single 100 MHz system clock; all pins are sampled on it.
package tx_clk_pkg;
    // System clock period in ns
    localparam int CLOCK_PERIOD_NS = 10;
    // Crystal reference and serial bit rate, in kHz
    localparam int XTAL_KHZ = 25000;
    localparam int BIT_KHZ = 125000;
    // Frequency multiplier ratio, bit clock over crystal
    localparam int MULT_RATIO = BIT_KHZ / XTAL_KHZ;
    // Bits per transmit symbol
    localparam int SYMBOL_BITS = 5;
    // Typical multiplier lock time, in ns, and its cycle count (rounded up)
    localparam int LOCK_TIME_NS = 2000;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int LOCK_CNT_W = 8;
    // Oscillator edges without an external edge before the input counts as idle
    localparam int IDLE_WINDOW = 8;
    localparam int IDLE_CNT_W = 4;
    // Sampled pin indices
    localparam int PIN_OSC = 0;
    localparam int PIN_EXT = 1;
    localparam int PIN_RX = 2;
    localparam int PIN_COUNT = 3;
    // Reset values of the outputs
    localparam logic CLK_OUT_RST = 1'b0;
    localparam logic [4:0] SYMBOL_RST = 5'h00;

    // Source selection states, Gray coded around the loop
    typedef enum logic [1:0] {
        S_MASTER = 2'h0,
        S_LOCK_SLAVE = 2'h1,
        S_SLAVE = 2'h3,
        S_LOCK_MASTER = 2'h2
    } src_state_t;
endpackage : tx_clk_pkg

// [src/tx_clock_select.sv]
// Transmit clock source selector: crystal master or external-clock slave.
// Assumes osc_ref_in is the crystal reference, ext_tx_clock_in the optional
// distributed clock and rx_vcxo_in the receive oscillator, all asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
module tx_clock_select #(
    parameter int IDLE_EDGES = tx_clk_pkg::IDLE_WINDOW
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic osc_ref_in,
    input wire logic ext_tx_clock_in,
    input wire logic rx_vcxo_in,
    input wire logic [4:0] tx_symbol_bus,
    output logic symbol_clock_out,
    output logic byte_clock_out,
    output logic recovered_rx_clock,
    output logic slave_mode,
    output logic [4:0] tx_symbol_out,
    output logic tx_symbol_valid
);
    // Symbol rate equals the crystal rate only because the ratio matches
    localparam bit RATIO_OK = (tx_clk_pkg::MULT_RATIO == tx_clk_pkg::SYMBOL_BITS);
    localparam logic [tx_clk_pkg::LOCK_CNT_W-1:0] LOCK_LOAD =
        tx_clk_pkg::LOCK_CNT_W'(tx_clk_pkg::LOCK_CYCLES - 1);
    localparam logic [tx_clk_pkg::IDLE_CNT_W-1:0] IDLE_LAST =
        tx_clk_pkg::IDLE_CNT_W'(IDLE_EDGES - 1);

    pin_edge_if #(.N(tx_clk_pkg::PIN_COUNT)) pin_bus ();

    pin_sampler #(.N(tx_clk_pkg::PIN_COUNT)) u_pins (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .pins({rx_vcxo_in, ext_tx_clock_in, osc_ref_in}),
        .edges(pin_bus.sampler)
    );

    logic [4:0] bus_meta_reg;
    logic [4:0] bus_sync_reg;
    logic osc_level;
    logic osc_rise;
    logic ext_level;
    logic ext_rise;
    logic rx_level;
    assign osc_level = pin_bus.level[tx_clk_pkg::PIN_OSC];
    assign osc_rise = pin_bus.rise[tx_clk_pkg::PIN_OSC];
    assign ext_level = pin_bus.level[tx_clk_pkg::PIN_EXT];
    assign ext_rise = pin_bus.rise[tx_clk_pkg::PIN_EXT];
    assign rx_level = pin_bus.level[tx_clk_pkg::PIN_RX];

    // Symbol bus passes two stages like every other pin
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_meta_reg <= tx_clk_pkg::SYMBOL_RST;
            bus_sync_reg <= tx_clk_pkg::SYMBOL_RST;
        end else if (ce) begin
            bus_meta_reg <= tx_symbol_bus;
            bus_sync_reg <= bus_meta_reg;
        end
    end

    // Activity detector on the external clock
    logic ext_active_reg;
    logic ext_active_next;
    logic [tx_clk_pkg::IDLE_CNT_W-1:0] idle_cnt_reg;
    logic [tx_clk_pkg::IDLE_CNT_W-1:0] idle_cnt_next;

    // An external edge restarts the window, so it wins over an expiring count
    always_comb begin
        ext_active_next = ext_active_reg;
        idle_cnt_next = idle_cnt_reg;
        if (ext_rise) begin
            ext_active_next = 1'b1;
            idle_cnt_next = '0;
        end else if (osc_rise && ext_active_reg) begin
            if (idle_cnt_reg == IDLE_LAST) begin
                ext_active_next = 1'b0;
                idle_cnt_next = '0;
            end else begin
                idle_cnt_next = idle_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_active_reg <= 1'b0;
            idle_cnt_reg <= '0;
        end else if (ce) begin
            ext_active_reg <= ext_active_next;
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    // Source state machine and clock outputs
    tx_clk_pkg::src_state_t state_reg;
    tx_clk_pkg::src_state_t state_next;
    logic [tx_clk_pkg::LOCK_CNT_W-1:0] lock_cnt_reg;
    logic [tx_clk_pkg::LOCK_CNT_W-1:0] lock_cnt_next;
    logic sym_next;
    logic byte_next;
    logic src_level;
    logic src_rise;

    // Leave an active state only while both clocks sit low, and re-enter
    // only on a low source phase; this costs up to a byte clock period of latency
    // but guarantees full-width pulses on both outputs
    always_comb begin
        state_next = state_reg;
        lock_cnt_next = lock_cnt_reg;
        src_level = 1'b0;
        src_rise = 1'b0;
        sym_next = tx_clk_pkg::CLK_OUT_RST;
        byte_next = tx_clk_pkg::CLK_OUT_RST;
        case (state_reg)
            tx_clk_pkg::S_MASTER: begin
                src_level = osc_level;
                src_rise = osc_rise;
                if (ext_active_reg && !osc_level && !byte_clock_out) begin
                    state_next = tx_clk_pkg::S_LOCK_SLAVE;
                    lock_cnt_next = LOCK_LOAD;
                end
            end
            tx_clk_pkg::S_LOCK_SLAVE: begin
                if (!ext_active_reg) begin
                    state_next = tx_clk_pkg::S_LOCK_MASTER;
                    lock_cnt_next = LOCK_LOAD;
                end else if (lock_cnt_reg != '0) begin
                    lock_cnt_next = lock_cnt_reg - 1'b1;
                end else if (!ext_level) begin
                    state_next = tx_clk_pkg::S_SLAVE;
                end
            end
            tx_clk_pkg::S_SLAVE: begin
                src_level = ext_level;
                src_rise = ext_rise;
                if (!ext_active_reg && !ext_level && !byte_clock_out) begin
                    state_next = tx_clk_pkg::S_LOCK_MASTER;
                    lock_cnt_next = LOCK_LOAD;
                end
            end
            tx_clk_pkg::S_LOCK_MASTER: begin
                if (ext_active_reg) begin
                    state_next = tx_clk_pkg::S_LOCK_SLAVE;
                    lock_cnt_next = LOCK_LOAD;
                end else if (lock_cnt_reg != '0) begin
                    lock_cnt_next = lock_cnt_reg - 1'b1;
                end else if (!osc_level) begin
                    state_next = tx_clk_pkg::S_MASTER;
                end
            end
            default: begin
                state_next = tx_clk_pkg::S_MASTER;
            end
        endcase
        // Clocks run only in an active state that is not about to be left
        if (state_next == state_reg &&
            (state_reg == tx_clk_pkg::S_MASTER || state_reg == tx_clk_pkg::S_SLAVE)) begin
            sym_next = src_level && RATIO_OK;
            byte_next = src_rise ? ~byte_clock_out : byte_clock_out;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= tx_clk_pkg::S_MASTER;
            lock_cnt_reg <= '0;
            symbol_clock_out <= tx_clk_pkg::CLK_OUT_RST;
            byte_clock_out <= tx_clk_pkg::CLK_OUT_RST;
            slave_mode <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            lock_cnt_reg <= lock_cnt_next;
            symbol_clock_out <= sym_next;
            byte_clock_out <= byte_next;
            slave_mode <= (state_next == tx_clk_pkg::S_SLAVE);
        end
    end

    // Symbol capture and receive clock
    logic [4:0] sym_cap_next;
    logic sym_valid_next;
    logic rx_clk_next;

    // Capture on the source pin edge itself (external in slave, oscillator in master), never on the derived symbol clock
    always_comb begin
        sym_cap_next = tx_symbol_out;
        sym_valid_next = 1'b0;
        rx_clk_next = rx_level;
        if (state_reg == tx_clk_pkg::S_SLAVE && ext_rise) begin
            sym_cap_next = bus_sync_reg;
            sym_valid_next = 1'b1;
        end else if (state_reg == tx_clk_pkg::S_MASTER && osc_rise) begin
            sym_cap_next = bus_sync_reg;
            sym_valid_next = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_symbol_out <= tx_clk_pkg::SYMBOL_RST;
            tx_symbol_valid <= 1'b0;
            recovered_rx_clock <= tx_clk_pkg::CLK_OUT_RST;
        end else if (ce) begin
            tx_symbol_out <= sym_cap_next;
            tx_symbol_valid <= sym_valid_next;
            recovered_rx_clock <= rx_clk_next;
        end
    end

    lock_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && (state_reg == tx_clk_pkg::S_LOCK_SLAVE || state_reg == tx_clk_pkg::S_LOCK_MASTER))
        |=> !symbol_clock_out && !byte_clock_out && !tx_symbol_valid)
        else $error("clock outputs not low while locking");
    master_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && state_reg == tx_clk_pkg::S_MASTER && state_next == tx_clk_pkg::S_MASTER)
        |=> symbol_clock_out == $past(osc_level))
        else $error("symbol clock not following oscillator");
    slave_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && state_reg == tx_clk_pkg::S_SLAVE && state_next == tx_clk_pkg::S_SLAVE)
        |=> symbol_clock_out == $past(ext_level) && slave_mode)
        else $error("symbol clock not following external clock");
    slave_capture_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && state_reg == tx_clk_pkg::S_SLAVE && ext_rise)
        |=> tx_symbol_valid && tx_symbol_out == $past(bus_sync_reg))
        else $error("symbol bus not captured on external edge");
    rx_clock_a: assert property (@(posedge clock) disable iff (sys_rst)
        ce |=> recovered_rx_clock == $past(rx_level))
        else $error("receive clock not driven");
    auto_slave_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && state_reg == tx_clk_pkg::S_MASTER && ext_active_reg && !osc_level
        && !byte_clock_out) |=> state_reg == tx_clk_pkg::S_LOCK_SLAVE
        && lock_cnt_reg == LOCK_LOAD)
        else $error("no switch toward slave");
    idle_master_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && state_reg == tx_clk_pkg::S_SLAVE && !ext_active_reg && !ext_level
        && !byte_clock_out) |=> state_reg == tx_clk_pkg::S_LOCK_MASTER)
        else $error("no fallback to oscillator");
    lock_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && state_reg == tx_clk_pkg::S_LOCK_SLAVE && lock_cnt_reg != '0
        && ext_active_reg) |=> state_reg == tx_clk_pkg::S_LOCK_SLAVE)
        else $error("lock wait cut short");
    byte_toggle_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && state_reg == tx_clk_pkg::S_MASTER && state_next == tx_clk_pkg::S_MASTER
        && osc_rise) |=> byte_clock_out != $past(byte_clock_out))
        else $error("byte clock missed a symbol edge");
endmodule : tx_clock_select
`default_nettype wire

// [testbench/station_model.sv]
// Station side model: crystal, shared transmit clock, receive oscillator, symbol source.
// Assumes the bench enables the shared clock and supplies the next symbol value.
`timescale 1ns/100ps
`default_nettype none
module station_model (
    input wire logic ext_en,
    input wire logic [4:0] next_sym,
    output logic osc_ref_in,
    output logic ext_tx_clock_in,
    output logic rx_vcxo_in,
    output logic [4:0] tx_symbol_bus
);
    // Crystal reference, 8 system cycles a period, phase off the system clock
    initial begin
        osc_ref_in = 1'b0;
        #3.3;
        forever #40 osc_ref_in = ~osc_ref_in;
    end

    // Shared distributed clock; finishes its high phase, then stands low when off
    initial begin
        ext_tx_clock_in = 1'b0;
        #7.7;
        forever begin
            #50;
            if (ext_en || ext_tx_clock_in) ext_tx_clock_in = ~ext_tx_clock_in;
        end
    end

    // Receive oscillator runs whatever the transmit side does
    initial begin
        rx_vcxo_in = 1'b0;
        #1.9;
        forever #60 rx_vcxo_in = ~rx_vcxo_in;
    end

    // Symbols launched from the source pins, never from the device's clock outputs
    initial tx_symbol_bus = 5'h00;
    always @(negedge osc_ref_in) if (!ext_en) tx_symbol_bus <= next_sym;
    always @(negedge ext_tx_clock_in) if (ext_en) tx_symbol_bus <= next_sym;
endmodule : station_model
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the transmit clock source selector.
// Assumes the station model drives every pin; the design carries its own assertions.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int IDLE_N = 4;
    localparam int OSC_P = 8;
    localparam int EXT_P = 10;
    localparam int RX_P = 12;
    localparam int WIN = 400;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic ext_en = 1'b0;
    logic ce_e = 1'b1;
    logic [4:0] next_sym = 5'h00;
    logic [31:0] lfsr = 32'h00012F38;
    wire osc_ref_in;
    wire ext_tx_clock_in;
    wire rx_vcxo_in;
    wire [4:0] tx_symbol_bus;
    logic symbol_clock_out, byte_clock_out, recovered_rx_clock, slave_mode, tx_symbol_valid;
    logic [4:0] tx_symbol_out;
    logic sym_prev = 1'b0;
    logic byte_prev = 1'b0;
    logic rx_prev = 1'b0;
    logic [15:0] snap;
    int errors = 0;
    int checked = 0;
    int sym_n, byte_n, rx_n, cap_n, hit;
    int run_len = 9;
    int byte_run = 9;

    station_model station_model_inst (.ext_en(ext_en), .next_sym(next_sym),
        .osc_ref_in(osc_ref_in), .ext_tx_clock_in(ext_tx_clock_in),
        .rx_vcxo_in(rx_vcxo_in), .tx_symbol_bus(tx_symbol_bus));

    tx_clock_select #(.IDLE_EDGES(IDLE_N)) tx_clock_select_inst (.clock(clock),
        .sys_rst(sys_rst), .ce(ce), .osc_ref_in(osc_ref_in),
        .ext_tx_clock_in(ext_tx_clock_in), .rx_vcxo_in(rx_vcxo_in),
        .tx_symbol_bus(tx_symbol_bus), .symbol_clock_out(symbol_clock_out),
        .byte_clock_out(byte_clock_out), .recovered_rx_clock(recovered_rx_clock),
        .slave_mode(slave_mode), .tx_symbol_out(tx_symbol_out),
        .tx_symbol_valid(tx_symbol_valid));

    always #5 clock = ~clock;

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check_val

    // Edge counts are sampled, so one edge either way is allowed
    task automatic check_near(input string what, input int exp, input int got);
        checked++;
        if (got < exp - 1 || got > exp + 1) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_near

    task automatic final_report;
        $display("comparisons %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // Waits for slave_mode to reach val; hit equals n if it never did
    task automatic watch(input logic val, input int n, output int hit);
        hit = 0;
        while (hit < n && slave_mode !== val) begin
            tick(1);
            hit++;
        end
    endtask : watch

    // Counts output edges over one window against the expected source period, the receive clock against RX_P
    task automatic measure(input int per);
        sym_n = 0;
        byte_n = 0;
        rx_n = 0;
        cap_n = 0;
        tick(WIN);
        check_near("symbol clock rises", WIN / per, sym_n);
        check_near("byte clock rises", WIN / (2 * per), byte_n);
        check_near("receive clock rises", WIN / RX_P, rx_n);
        check_near("captures", WIN / per, cap_n);
    endtask : measure

    // Random symbols, with the all-ones corner now and then
    always @(posedge clock) begin
        #1;
        lfsr = lfsr_step(lfsr);
        next_sym <= (lfsr[7:5] == 3'h0) ? 5'h1F : lfsr[4:0];
    end

    // Edge counters, pulse width watch and capture check, after outputs settle
    always @(posedge clock) begin
        ce_e = ce;
        #2;
        if (symbol_clock_out === 1'b1 && sym_prev === 1'b0) sym_n++;
        if (byte_clock_out === 1'b1 && byte_prev === 1'b0) byte_n++;
        if (recovered_rx_clock === 1'b1 && rx_prev === 1'b0) rx_n++;
        if (sys_rst) run_len = 9;
        else if (symbol_clock_out !== sym_prev) begin
            check_val("symbol run length", 16'h0001, {15'h0000, run_len >= 2});
            run_len = 1;
        end else run_len++;
        // Byte clock must never show a runt either, across every source change
        if (sys_rst) byte_run = 9;
        else if (byte_clock_out !== byte_prev) begin
            check_val("byte run length", 16'h0001, {15'h0000, byte_run >= 2});
            byte_run = 1;
        end else byte_run++;
        // Skipped while the selector is still catching up with the source
        if (tx_symbol_valid === 1'b1 && ce_e && slave_mode === ext_en) begin
            cap_n++;
            check_val("captured symbol", {11'h000, tx_symbol_bus}, {11'h000, tx_symbol_out});
        end
        sym_prev = symbol_clock_out;
        byte_prev = byte_clock_out;
        rx_prev = recovered_rx_clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        final_report();
    end

    initial begin
        tick(16);
        check_val("outputs in reset", 16'h0000, {10'h000, symbol_clock_out, byte_clock_out,
            slave_mode, tx_symbol_valid, 2'h0});
        sys_rst = 1'b0;
        tick(20);
        measure(OSC_P);
        ext_en = 1'b1;
        watch(1'b1, 400, hit);
        check_val("slave entry", 16'h0001, {15'h0000, hit < 400});
        tick(20);
        measure(EXT_P);
        // Freeze with ce low while the pins keep toggling
        ce = 1'b0;
        tick(1);
        snap = {5'h00, symbol_clock_out, byte_clock_out, recovered_rx_clock, slave_mode,
            tx_symbol_valid, tx_symbol_out, 1'b0};
        tick(20);
        check_val("frozen outputs", snap, {5'h00, symbol_clock_out, byte_clock_out,
            recovered_rx_clock, slave_mode, tx_symbol_valid, tx_symbol_out, 1'b0});
        ce = 1'b1;
        ext_en = 1'b0;
        watch(1'b0, 500, hit);
        check_val("master return", 16'h0001, {15'h0000, hit < 500});
        // slave_mode drops on entry to the lock wait, so let the multiplier lock first
        tick(tx_clk_pkg::LOCK_CYCLES + 30);
        measure(OSC_P);
        // Shared clock appears only briefly: the lock must fall back without a slave stint
        ext_en = 1'b1;
        tick(60);
        ext_en = 1'b0;
        watch(1'b1, 500, hit);
        check_val("aborted lock", 16'h0000, {15'h0000, hit < 500});
        // Reset in mid slave run, then automatic re-entry
        ext_en = 1'b1;
        watch(1'b1, 400, hit);
        check_val("slave before reset", 16'h0001, {15'h0000, hit < 400});
        sys_rst = 1'b1;
        tick(2);
        check_val("slave in reset", 16'h0000, {14'h0000, slave_mode, symbol_clock_out});
        sys_rst = 1'b0;
        watch(1'b1, 400, hit);
        check_val("slave re-entry", 16'h0001, {15'h0000, hit < 400});
        tick(20);
        measure(EXT_P);
        final_report();
    end
endmodule : tb
`default_nettype wire
